// [rtl/mpg_top.sv]
// Overview of operation
// - one enable bit per motor pin
// - enable register h'c0 on reset, standby
// - enable bits 7..6 read as one
// - level control clears on reset, standby
// - settings act only in pwm modes
// - bit 6 enables period toggle output
// - bit 1 sets negative phase levels
// - bit 0 sets positive phase levels
// - negative phase holds initial until dead time
// - gate control h'80 on reset, standby
// - gate control bit 7 reads as one
// - bit 6 selects brushless gate outputs
// - bit 5 chops negative phase gates
// - bit 4 chops positive phase gates
// - bit 3 selects feedback source
// - phase bits used only from register
// - phase pattern decodes to pin pairs
// - stopped counter returns pin to initial
`include "mpg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module mpg_top
    import mpg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic standby_in,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // timer waveform side
    input wire mpg_mode_t tmr_mode,
    input wire logic [1:0] tmr_run,
    input wire logic tmr_dead_done,
    input wire logic tmr_period_tick,
    input wire logic [2:0] tmr_pos_act,
    input wire logic [2:0] tmr_neg_act,
    input wire logic [5:0] tmr_plain_out,
    // feedback capture pins, w v u
    input wire logic [2:0] fb_pin,
    // motor pins
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe_n,
    output logic period_toggle_out
);

    mpg_state_t s_q;
    mpg_state_t s_d;
    mpg_req_t req;
    mpg_tmr_t tmr;

    logic pwm_mode;
    logic [2:0] wvu;
    logic [2:0] gate_pos;
    logic [2:0] gate_neg;
    logic [5:0] pin_lvl;
    logic init_rst;

    assign req = '{addr: reg_addr, wdata: reg_wdata,
                   we: reg_we, re: reg_re};
    assign tmr = '{mode: tmr_mode, run: tmr_run,
                   dead_done: tmr_dead_done,
                   period_tick: tmr_period_tick,
                   pos_act: tmr_pos_act,
                   neg_act: tmr_neg_act,
                   plain_out: tmr_plain_out};

    assign init_rst = sys_rst | standby_in;

    // only the two pwm modes let the settings act
    assign pwm_mode = (tmr.mode == MPG_COMP_PWM) ||
                      (tmr.mode == MPG_RSYNC_PWM);

    // feedback source: register bits or synchronised pins
    assign wvu = s_q.gate[`MPG_GATE_FB] ?
                 s_q.gate[2:0] : s_q.fb_s2;

    // commutation decode, positive and negative u v w
    always_comb begin
        gate_pos = 3'h0;
        gate_neg = 3'h0;
        case (wvu)
            3'h1: begin
                gate_pos = 3'h1;
                gate_neg = 3'h4;
            end
            3'h2: begin
                gate_pos = 3'h2;
                gate_neg = 3'h1;
            end
            3'h3: begin
                gate_pos = 3'h2;
                gate_neg = 3'h4;
            end
            3'h4: begin
                gate_pos = 3'h4;
                gate_neg = 3'h2;
            end
            3'h5: begin
                gate_pos = 3'h1;
                gate_neg = 3'h2;
            end
            3'h6: begin
                gate_pos = 3'h4;
                gate_neg = 3'h1;
            end
            default: begin
                gate_pos = 3'h0;
                gate_neg = 3'h0;
            end
        endcase
    end

    // per pin level: 0..2 positive u v w, 3..5 negative u v w
    for (genvar i = 0; i < `MPG_NPIN; i++) begin : g_pin
        localparam bit NEG = (i >= `MPG_NEG_BASE);
        localparam int PH = i % `MPG_NEG_BASE;
        localparam int CH = (PH == 0) ? 0 : 1;
        logic ols;
        logic chop;
        logic act;
        logic gate_on;
        logic hold;
        if (NEG) begin : g_neg
            assign ols = s_q.lvl[`MPG_LVL_NEG];
            assign chop = s_q.gate[`MPG_GATE_CHOP_N];
            assign act = tmr.neg_act[PH];
            assign gate_on = gate_neg[PH];
            assign hold = ~tmr.run[CH] |
                          ~tmr.dead_done;
        end else begin : g_pos
            assign ols = s_q.lvl[`MPG_LVL_POS];
            assign chop = s_q.gate[`MPG_GATE_CHOP_P];
            assign act = tmr.pos_act[PH];
            assign gate_on = gate_pos[PH];
            assign hold = ~tmr.run[CH];
        end
        logic want;
        // brushless: gate direct or gate chopped by the pwm waveform; otherwise the pwm waveform
        assign want = s_q.gate[`MPG_GATE_BDC] ?
                      (gate_on & (chop ? act : 1'b1)) : act;
        // active level equals ols, initial is its inverse
        assign pin_lvl[i] = !pwm_mode ? tmr.plain_out[i] :
                            hold ? ~ols :
                            (want ? ols : ~ols);
    end

    always_comb begin
        s_d = s_q;
        // feedback pins, two stage synchroniser
        s_d.fb_s1 = fb_pin;
        s_d.fb_s2 = s_q.fb_s1;
        // register writes
        if (req.we) begin
            case (req.addr)
                `MPG_OFS_PIN_EN: begin
                    s_d.pin_en = `MPG_PIN_EN_FIXED |
                        (req.wdata & `MPG_PIN_EN_WMASK);
                end
                `MPG_OFS_LVL: begin
                    s_d.lvl = req.wdata & `MPG_LVL_WMASK;
                end
                `MPG_OFS_GATE: begin
                    s_d.gate = `MPG_GATE_FIXED |
                        (req.wdata & `MPG_GATE_WMASK);
                end
                default: begin
                    s_d.pin_en = s_q.pin_en;
                end
            endcase
        end
        // register reads, data one cycle later
        s_d.rdata = 8'h00;
        if (req.re) begin
            case (req.addr)
                `MPG_OFS_PIN_EN: s_d.rdata = s_q.pin_en;
                `MPG_OFS_LVL: s_d.rdata = s_q.lvl;
                `MPG_OFS_GATE: s_d.rdata = s_q.gate;
                default: s_d.rdata = 8'h00;
            endcase
        end
        // period toggle
        if (!pwm_mode || !s_q.lvl[`MPG_LVL_TOGGLE]) begin
            s_d.toggle = 1'b0;
        end else if (tmr.period_tick) begin
            s_d.toggle = ~s_q.toggle;
        end
        // pins, one edge after the decode
        s_d.pin_out = pin_lvl;
        s_d.pin_oe_n = ~s_q.pin_en[5:0];
        // power-on reset and standby; manual reset has no input
        if (init_rst) begin
            s_d.pin_en = `MPG_PIN_EN_RST;
            s_d.lvl = `MPG_LVL_RST;
            s_d.gate = `MPG_GATE_RST;
            s_d.toggle = 1'b0;
            s_d.rdata = 8'h00;
            s_d.pin_oe_n = 6'h3f;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '{pin_en: `MPG_PIN_EN_RST,
                     lvl: `MPG_LVL_RST,
                     gate: `MPG_GATE_RST,
                     fb_s1: 3'h0,
                     fb_s2: 3'h0,
                     rdata: 8'h00,
                     pin_out: 6'h00,
                     pin_oe_n: 6'h3f,
                     toggle: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign pin_out = s_q.pin_out;
    assign pin_oe_n = s_q.pin_oe_n;
    assign period_toggle_out = s_q.toggle;

    // enable bit gates the pin drive one edge after it is set
    a_pin_enable_gate:
    assert property (@(posedge clk) disable iff (sys_rst)
        !init_rst ##1 !init_rst |->
        pin_oe_n == ~$past(s_q.pin_en[5:0]))
    else $error("pin enable does not gate the drive");

    // standby loads the documented values
    a_init_values:
    assert property (@(posedge clk) disable iff (sys_rst)
        standby_in |=> s_q.pin_en == 8'hc0 &&
        s_q.lvl == 8'h00 && s_q.gate == 8'h80)
    else $error("standby did not load initial values");

    // fixed bits read as one, except a read in reset or standby returns 00
    a_fixed_ones:
    assert property (@(posedge clk) disable iff (sys_rst)
        req.re && req.addr == 2'h0 |=> reg_rdata[7:6] == 2'h3)
    else $error("enable bits 7..6 not read as one");

    a_gate_bit7:
    assert property (@(posedge clk) disable iff (sys_rst)
        req.re && req.addr == 2'h2 |=> reg_rdata[7])
    else $error("gate bit 7 not read as one");

    // level control clears on standby
    a_lvl_clear:
    assert property (@(posedge clk) disable iff (sys_rst)
        standby_in |=> s_q.lvl == 8'h00)
    else $error("level control not cleared");

    // outside pwm modes the plain output passes through
    a_plain_pass:
    assert property (@(posedge clk) disable iff (sys_rst)
        !pwm_mode |=> pin_out == $past(tmr_plain_out))
    else $error("settings acted outside pwm mode");

    // toggle stays low unless enabled in a pwm mode
    a_toggle_off:
    assert property (@(posedge clk) disable iff (sys_rst)
        !s_q.lvl[6] |=> !period_toggle_out)
    else $error("toggle output while disabled");

    a_toggle_flip:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.lvl[6] && tmr_period_tick &&
        !init_rst |=> period_toggle_out != $past(s_q.toggle))
    else $error("toggle missed a period tick");

    // negative pins hold initial level before dead time
    a_dead_hold:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && !tmr_dead_done |=>
        pin_out[5:3] == {3{~$past(s_q.lvl[1])}})
    else $error("negative pin left initial level early");

    // stopped channel 3 pins return to initial level
    a_stop_init:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && !tmr_run[0] |=>
        pin_out[0] == ~$past(s_q.lvl[0]) &&
        pin_out[3] == ~$past(s_q.lvl[1]))
    else $error("stopped pin not at initial level");

    // decode with register feedback, unchopped, running
    a_decode_uw:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.gate[6:3] == 4'h9 &&
        s_q.gate[2:0] == 3'h1 && &tmr_run &&
        tmr_dead_done |=>
        pin_out[0] == $past(s_q.lvl[0]) &&
        pin_out[5] == $past(s_q.lvl[1]) &&
        pin_out[1] == ~$past(s_q.lvl[0]))
    else $error("phase pattern 001 decoded wrongly");

    // external feedback reaches the decode after two edges
    a_fb_sync:
    assert property (@(posedge clk) disable iff (sys_rst)
        !s_q.gate[3] ##2 !s_q.gate[3] |->
        wvu == $past(fb_pin, 2))
    else $error("feedback pins not synchronised");

    // chopping follows the pwm waveform
    a_chop_pos:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.gate[6] && s_q.gate[4] &&
        gate_pos[0] && tmr_run[0] && !tmr_pos_act[0] |=>
        pin_out[0] == ~$past(s_q.lvl[0]))
    else $error("positive gate not chopped");

    a_chop_neg:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.gate[6] && s_q.gate[5] &&
        gate_neg[2] && tmr_run[1] && tmr_dead_done &&
        !tmr_neg_act[2] |=> pin_out[5] == ~$past(s_q.lvl[1]))
    else $error("negative gate not chopped");

    // with brushless mode off the pwm waveform drives pins
    a_bdc_off:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && !s_q.gate[6] && tmr_run[0] &&
        tmr_pos_act[0] |=> pin_out[0] == $past(s_q.lvl[0]))
    else $error("ordinary output not following pwm");

    // register phase bits ignored when external source chosen
    a_phase_ignored:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.gate[6:3] == 4'h8 && s_q.fb_s2 == 3'h0 &&
        &tmr_run && tmr_dead_done |=>
        pin_out == {{3{~$past(s_q.lvl[1])}}, {3{~$past(s_q.lvl[0])}}})
    else $error("phase bits used with external feedback");

    // a write to the enable register lands in bits 5..0
    a_enable_write:
    assert property (@(posedge clk) disable iff (sys_rst)
        req.we && req.addr == 2'h0 && !init_rst |=>
        s_q.pin_en == {2'h3, $past(req.wdata[5:0])})
    else $error("enable register write lost");

    a_gate_write:
    assert property (@(posedge clk) disable iff (sys_rst)
        req.we && req.addr == 2'h2 && !init_rst |=>
        s_q.gate == {1'b1, $past(req.wdata[6:0])})
    else $error("gate register write lost");

    a_lvl_write:
    assert property (@(posedge clk) disable iff (sys_rst)
        req.we && req.addr == 2'h1 && !init_rst |=>
        s_q.lvl == ($past(req.wdata) & 8'h43))
    else $error("level register write lost");

    // codes 000 and 111 switch every gate off
    a_decode_off:
    assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.gate[6:4] == 3'h4 &&
        (wvu == 3'h0 || wvu == 3'h7) && &tmr_run &&
        tmr_dead_done |=>
        pin_out == {{3{~$past(s_q.lvl[1])}}, {3{~$past(s_q.lvl[0])}}})
    else $error("idle phase code drove a gate");

    // standby releases every motor pin
    a_standby_oe:
    assert property (@(posedge clk) disable iff (sys_rst)
        standby_in |=> pin_oe_n == 6'h3f)
    else $error("pins still driven after standby");

endmodule

`default_nettype wire

// [rtl/mpg_cfg.svh]
`ifndef MPG_CFG_SVH
`define MPG_CFG_SVH

// register offsets on the plain port
`define MPG_ADDR_W 2
`define MPG_OFS_PIN_EN 2'h0
`define MPG_OFS_LVL 2'h1
`define MPG_OFS_GATE 2'h2

// reset values
`define MPG_PIN_EN_RST 8'hc0
`define MPG_LVL_RST 8'h00
`define MPG_GATE_RST 8'h80

// fixed read bits
`define MPG_PIN_EN_FIXED 8'hc0
`define MPG_PIN_EN_WMASK 8'h3f
`define MPG_LVL_WMASK 8'h43
`define MPG_GATE_FIXED 8'h80
`define MPG_GATE_WMASK 8'h7f

// level control fields
`define MPG_LVL_TOGGLE 6
`define MPG_LVL_NEG 1
`define MPG_LVL_POS 0

// gate control fields
`define MPG_GATE_BDC 6
`define MPG_GATE_CHOP_N 5
`define MPG_GATE_CHOP_P 4
`define MPG_GATE_FB 3
`define MPG_GATE_W 2
`define MPG_GATE_V 1
`define MPG_GATE_U 0

// pin count and the first negative-phase pin
`define MPG_NPIN 6
`define MPG_NEG_BASE 3

`endif

// [rtl/mpg_pkg.sv]
package mpg_pkg;

    // counter mode of channels 3 and 4
    typedef enum logic [1:0] {
        MPG_ORDINARY,
        MPG_COMP_PWM,
        MPG_RSYNC_PWM
    } mpg_mode_t;

    // register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } mpg_req_t;

    // timer side waveform inputs
    typedef struct packed {
        mpg_mode_t mode;
        logic [1:0] run;
        logic dead_done;
        logic period_tick;
        logic [2:0] pos_act;
        logic [2:0] neg_act;
        logic [5:0] plain_out;
    } mpg_tmr_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0] pin_en;
        logic [7:0] lvl;
        logic [7:0] gate;
        logic [2:0] fb_s1;
        logic [2:0] fb_s2;
        logic [7:0] rdata;
        logic [5:0] pin_out;
        logic [5:0] pin_oe_n;
        logic toggle;
    } mpg_state_t;

endpackage

// [testbench/mpg_gate_drv.sv]
`timescale 1ns/1ps
`default_nettype none

module mpg_gate_drv (
    // clock
    input wire logic clk,
    // motor pins from the block
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe_n,
    // rotor position from the bench, w v u
    input wire logic [2:0] rotor_pos,
    // wire levels and hall sensors
    output logic [5:0] wire_lvl,
    output logic [2:0] fb_pin
);
    logic [5:0] last_q = 6'h00;

    // hall sensors follow the rotor a cycle late
    always_ff @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            if (!pin_oe_n[i]) begin
                last_q[i] <= pin_out[i];
            end
        end
        fb_pin <= rotor_pos;
    end

    // a released pin shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            wire_lvl[i] = pin_oe_n[i] ? ~last_q[i] : pin_out[i];
        end
    end
endmodule

`default_nettype wire

// [testbench/mpg_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module mpg_top_tb
    import mpg_pkg::*;
;
    logic clk, sys_rst, standby_in, reg_we, reg_re, tmr_dead_done;
    logic tmr_period_tick, period_toggle_out;
    logic [1:0] reg_addr, tmr_run;
    logic [7:0] reg_wdata, reg_rdata;
    mpg_mode_t tmr_mode;
    logic [2:0] tmr_pos_act, tmr_neg_act, fb_pin, rotor_pos;
    logic [5:0] tmr_plain_out, pin_out, pin_oe_n, wire_lvl;
    int err_total = 0;
    int samples_checked = 0;
    // gate pattern per phase code, {w,v,u neg, w,v,u pos}
    localparam logic [5:0] DEC [8] = '{6'h00, 6'h21, 6'h0a, 6'h22,
        6'h14, 6'h11, 6'h0c, 6'h00};

    mpg_top i_mpg_top (.clk(clk), .sys_rst(sys_rst),
        .standby_in(standby_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .tmr_mode(tmr_mode), .tmr_run(tmr_run),
        .tmr_dead_done(tmr_dead_done), .tmr_period_tick(tmr_period_tick),
        .tmr_pos_act(tmr_pos_act), .tmr_neg_act(tmr_neg_act),
        .tmr_plain_out(tmr_plain_out), .fb_pin(fb_pin), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .period_toggle_out(period_toggle_out));

    mpg_gate_drv i_mpg_gate_drv (.clk(clk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .rotor_pos(rotor_pos), .wire_lvl(wire_lvl),
        .fb_pin(fb_pin));

    always #5 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic pins(input logic [5:0] exp);
        settle(3);
        chk({2'h0, wire_lvl}, {2'h0, exp});
        @(posedge clk);
    endtask

    task automatic tick();
        @(posedge clk);
        tmr_period_tick <= 1'b1;
        @(posedge clk);
        tmr_period_tick <= 1'b0;
    endtask

    // level of each pin from its on state and the two select bits
    function automatic logic [5:0] lvl_map(input logic [5:0] on,
        input logic [1:0] s);
        return ~(on ^ {{3{s[1]}}, {3{s[0]}}});
    endfunction

    task automatic test_done();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        test_done();
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        standby_in = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
        tmr_mode = MPG_ORDINARY;
        tmr_run = 2'h3;
        tmr_dead_done = 1'b1;
        tmr_period_tick = 1'b0;
        tmr_pos_act = 3'h0;
        tmr_neg_act = 3'h0;
        tmr_plain_out = 6'h00;
        rotor_pos = 3'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(2'h0, 8'hc0);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h80);
        rd(2'h3, 8'h00);
        chk({2'h0, pin_oe_n}, 8'h3f);
        // read-only bits and the unmapped place
        wr(2'h0, 8'h00);
        rd(2'h0, 8'hc0);
        wr(2'h2, 8'h7f);
        rd(2'h2, 8'hff);
        wr(2'h1, 8'hff);
        rd(2'h1, 8'h43);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'h15);
        settle(2);
        chk({2'h0, pin_oe_n}, 8'h2a);
        wr(2'h0, 8'hff);
        settle(2);
        chk({2'h0, pin_oe_n}, 8'h00);
        @(posedge clk);
        // outside the pwm modes the settings do nothing
        tmr_plain_out <= 6'h2d;
        tmr_pos_act <= 3'h7;
        pins(6'h2d);
        tick();
        settle(2);
        chk({7'h0, period_toggle_out}, 8'h00);
        // plain pwm levels for every select pair
        wr(2'h2, 8'h80);
        tmr_mode <= MPG_COMP_PWM;
        for (int s = 0; s < 4; s++) begin
            wr(2'h1, 8'(s));
            for (int k = 0; k < 4; k++) begin
                tmr_pos_act <= 3'(6'h15 * k);
                tmr_neg_act <= 3'((6'h15 * k) >> 3);
                pins(lvl_map(6'(6'h15 * k), 2'(s)));
            end
        end
        tmr_dead_done <= 1'b0;
        pins(6'h07);
        tmr_dead_done <= 1'b1;
        tmr_run <= 2'h2;
        pins(6'h36);
        tmr_run <= 2'h0;
        pins(6'h00);
        tmr_run <= 2'h3;
        // commutation from the phase bits
        for (int c = 0; c < 8; c++) begin
            wr(2'h2, 8'hc8 | 8'(c));
            pins(DEC[c]);
        end
        tmr_pos_act <= 3'h0;
        tmr_neg_act <= 3'h7;
        wr(2'h2, 8'hd9);
        pins(6'h20);
        tmr_pos_act <= 3'h7;
        tmr_neg_act <= 3'h0;
        wr(2'h2, 8'he9);
        pins(6'h01);
        // commutation from the hall sensors, phase bits ignored
        wr(2'h2, 8'hc5);
        for (int c = 0; c < 8; c++) begin
            rotor_pos <= 3'(c);
            settle(2);
            pins(DEC[c]);
        end
        // period toggle in reset-synchronised mode
        tmr_mode <= MPG_RSYNC_PWM;
        wr(2'h1, 8'h43);
        tick();
        tick();
        tick();
        settle(2);
        chk({7'h0, period_toggle_out}, 8'h01);
        wr(2'h1, 8'h03);
        settle(2);
        chk({7'h0, period_toggle_out}, 8'h00);
        // standby reinitialises all three registers
        @(posedge clk);
        standby_in <= 1'b1;
        @(posedge clk);
        standby_in <= 1'b0;
        rd(2'h0, 8'hc0);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h80);
        settle(1);
        chk({2'h0, pin_oe_n}, 8'h3f);
        test_done();
    end
endmodule

`default_nettype wire
